/* File: hdl/dssc_top.sv */
// Purpose: Seek, sense drive status, sense interrupt and set track command handling
// Assumes: APB slave on pclk; drive status inputs synchronous to pclk
// Notes: Specify parameters and extended range come from the config register
// What this block does
// - Seek steps the selected drive until the requested track is reached.
// - Extended range makes tracks 12-bit; fourth seek byte carries upper nibble.
// - After the last seek byte the selected drive's busy bit sets.
// - Command side goes idle at once, then delay-before-processing runs before first step.
// - Compare target with present track for step count and direction.
// - Steps run during polling, spaced by the programmed step rate.
// - Interrupt one step period after last pulse; seek has no result bytes.
// - Sense drive status returns one status-3 byte and no interrupt.
// - Sense interrupt with nothing pending is an invalid command.
// - Positioning and polling interrupts clear on first sense interrupt result read.
// - Drive-ready polling interrupt is reported only after reset.
// - Status-0 bits 7..5 give cause: 110 poll, 001 normal, 01x abnormal.
// - Routine command interrupts clear by themselves, no sense interrupt needed.
// - Main status bit 7 shows the host request flag.
// - Sense interrupt returns status 0, track low byte, and nibble if extended.
// - Set track reads or writes the stored present track, no interrupt.
// - Step interval is sixteen minus step rate, scaled by data rate.
// - Drive codes 2 and 3 need four-drive mode; code 2 also exchange.
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "dssc_defs.svh"
module dssc_top #(
	parameter logic [7:0] CYC_PER_US = 8'(`DSSC_CLK_MHZ)
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [3:0] drive_ready,
	input wire logic [3:0] track_zero,
	input wire logic [3:0] write_protect,
	output logic step_n,
	output logic dir_out,
	output logic [1:0] drive_sel,
	output logic head_sel,
	output logic int_req
);
	localparam logic [7:0] STEP_W_CYC = 8'(`DSSC_STEP_WIDTH_US * CYC_PER_US);

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic pready_q, pready_d, pslverr_q, pslverr_d;
	logic [31:0] prdata_q, prdata_d, cfg_q, cfg_d;
	dssc_pkg::dssc_cmd_t st_q, st_d;
	logic [7:0] op_q, op_d;
	logic [1:0] need_q, need_d, bcnt_q, bcnt_d, rcnt_q, rcnt_d, ridx_q, ridx_d;
	logic [7:0] par_q [0:3];
	logic [7:0] par_d [0:3];
	logic [7:0] res_q [0:3];
	logic [7:0] res_d [0:3];
	dssc_pkg::dssc_track_t trk_q [0:3];
	dssc_pkg::dssc_track_t trk_d [0:3];
	logic int_q, int_d, poll_q, poll_d, head_q, head_d;
	logic [7:0] cause_q, cause_d;
	logic [3:0] busy_q, busy_d;
	logic [1:0] sel_q, sel_d;
	dssc_pkg::dssc_seek_t sk_q, sk_d;
	logic [1:0] skdrv_q, skdrv_d;
	dssc_pkg::dssc_track_t sktgt_q, sktgt_d, steps_q, steps_d;
	logic dir_q, dir_d, abn_q, abn_d, step_n_q, step_n_d;
	logic [7:0] wcnt_q, wcnt_d;
	logic acc, wr_data, rd_data, host_request_flag;
	logic seek_go, sk_fin, do_pulse, tstart, tdone, msb;
	logic [1:0] ds, pick;
	dssc_pkg::dssc_track_t cur, tgt;
	logic [7:0] tmult, sk_cause;
	logic [11:0] tunit;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic dssc_drv_ok(input logic [1:0] d, input logic [31:0] c);
		return !d[1] || c[`DSSC_CFG_FOUR] || (d == 2'h2 && c[`DSSC_CFG_EXCH]);
	endfunction

	// Exchange swaps logical drives 0 and 2 onto the physical lines
	function automatic logic [1:0] dssc_phys(input logic [1:0] d, input logic [31:0] c);
		return (c[`DSSC_CFG_EXCH] && !d[0]) ? {~d[1], 1'b0} : d;
	endfunction

	function automatic logic [11:0] dssc_step_unit(input logic [1:0] r);
		unique case (r)
			`DSSC_RATE_1M: return `DSSC_STEP_US_1M;
			`DSSC_RATE_500K: return `DSSC_STEP_US_500K;
			`DSSC_RATE_300K: return `DSSC_STEP_US_300K;
			`DSSC_RATE_250K: return `DSSC_STEP_US_250K;
		endcase
	endfunction

	function automatic logic [11:0] dssc_dbp_unit(input logic [1:0] r);
		unique case (r)
			`DSSC_RATE_1M, `DSSC_RATE_500K: return `DSSC_DBP_US_FAST;
			`DSSC_RATE_300K: return `DSSC_DBP_US_300K;
			`DSSC_RATE_250K: return `DSSC_DBP_US_250K;
		endcase
	endfunction

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	assign acc = psel && penable && pready_q;
	assign wr_data = acc && pwrite && (paddr == `DSSC_ADDR_DATA);
	assign rd_data = acc && !pwrite && (paddr == `DSSC_ADDR_DATA);
	assign host_request_flag = (st_q != dssc_pkg::CMD_EXEC);

	always_comb begin
		pready_d = 1'b0;
		pslverr_d = 1'b0;
		prdata_d = prdata_q;
		cfg_d = cfg_q;
		if (psel && penable && !pready_q) begin
			pready_d = 1'b1;
			prdata_d = 32'h0;
			case (paddr)
				`DSSC_ADDR_DATA: begin
					if (!pwrite && st_q == dssc_pkg::CMD_RESULT)
						prdata_d = {24'h0, res_q[ridx_q]};
				end
				`DSSC_ADDR_STAT: begin
					prdata_d = {24'h0, host_request_flag, st_q == dssc_pkg::CMD_RESULT, 1'b0,
						st_q != dssc_pkg::CMD_OPCODE, busy_q};
				end
				`DSSC_ADDR_CFG: prdata_d = cfg_q;
				default: pslverr_d = 1'b1;
			endcase
		end
		if (acc && pwrite && paddr == `DSSC_ADDR_CFG)
			cfg_d = pwdata & `DSSC_CFG_MASK;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0;
			cfg_q <= `DSSC_CFG_RST;
		end else begin
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			prdata_q <= prdata_d;
			cfg_q <= cfg_d;
		end
	end

	// ----------------------------------------
	// Command interpreter
	// ----------------------------------------
	always_comb begin
		st_d = st_q;
		op_d = op_q;
		need_d = need_q;
		bcnt_d = bcnt_q;
		par_d = par_q;
		res_d = res_q;
		rcnt_d = rcnt_q;
		ridx_d = ridx_q;
		int_d = int_q;
		cause_d = cause_q;
		trk_d = trk_q;
		busy_d = busy_q;
		poll_d = poll_q;
		sel_d = sel_q;
		head_d = head_q;
		seek_go = 1'b0;
		pick = 2'h0;
		ds = par_q[0][1:0];
		msb = par_q[0][2];
		cur = trk_q[ds];
		tgt = cfg_q[`DSSC_CFG_XTR] ? {par_q[2][7:4], par_q[1]} : {4'h0, par_q[1]};
		unique case (st_q)
			dssc_pkg::CMD_OPCODE: if (wr_data) begin
				op_d = pwdata[7:0];
				bcnt_d = 2'h0;
				st_d = dssc_pkg::CMD_PARAM;
				if (pwdata[7:0] == `DSSC_OP_SEEK)
					need_d = cfg_q[`DSSC_CFG_XTR] ? `DSSC_SEEK_BYTES_XTR : `DSSC_SEEK_BYTES;
				else if (pwdata[7:0] == `DSSC_OP_SENSE_DRV)
					need_d = `DSSC_SDS_BYTES;
				else if ((pwdata[7:0] & `DSSC_OP_SET_TRK_MASK) == `DSSC_OP_SET_TRK)
					need_d = `DSSC_STRK_BYTES;
				else
					st_d = dssc_pkg::CMD_EXEC;
			end
			dssc_pkg::CMD_PARAM: if (wr_data) begin
				par_d[bcnt_q] = pwdata[7:0];
				bcnt_d = bcnt_q + 2'h1;
				if (bcnt_q + 2'h1 == need_q)
					st_d = dssc_pkg::CMD_EXEC;
			end
			dssc_pkg::CMD_EXEC: begin
				st_d = dssc_pkg::CMD_RESULT;
				ridx_d = 2'h0;
				rcnt_d = `DSSC_ONE_RES;
				res_d[0] = `DSSC_CAUSE_INVALID;
				if (op_q == `DSSC_OP_SEEK) begin
					// A second seek while one runs is refused as invalid
					if (sk_q == dssc_pkg::SK_IDLE && dssc_drv_ok(ds, cfg_q)) begin
						seek_go = 1'b1;
						busy_d[ds] = 1'b1;
						sel_d = dssc_phys(ds, cfg_q);
						head_d = msb;
						st_d = dssc_pkg::CMD_OPCODE;
					end
				end else if (op_q == `DSSC_OP_SENSE_DRV) begin
					if (dssc_drv_ok(ds, cfg_q))
						res_d[0] = {1'b0, write_protect[dssc_phys(ds, cfg_q)],
							drive_ready[dssc_phys(ds, cfg_q)], track_zero[dssc_phys(ds, cfg_q)],
							`DSSC_DSTAT_TWO_SIDE, msb, ds};
				end else if (op_q == `DSSC_OP_SENSE_INT) begin
					if (int_q) begin
						res_d[0] = cause_q;
						res_d[1] = trk_q[cause_q[1:0]][7:0];
						res_d[2] = {trk_q[cause_q[1:0]][11:8], 4'h0};
						rcnt_d = cfg_q[`DSSC_CFG_XTR] ? `DSSC_SINT_RES_XTR : `DSSC_SINT_RES;
					end
				end else if ((op_q & `DSSC_OP_SET_TRK_MASK) == `DSSC_OP_SET_TRK
					&& par_q[0][7:3] == `DSSC_STRK_TAG && dssc_drv_ok(ds, cfg_q)) begin
					if (op_q[`DSSC_OP_WNR] && msb)
						trk_d[ds][11:8] = par_q[1][3:0];
					else if (op_q[`DSSC_OP_WNR])
						trk_d[ds][7:0] = par_q[1];
					res_d[0] = msb ? {4'h0, trk_d[ds][11:8]} : trk_d[ds][7:0];
				end
			end
			dssc_pkg::CMD_RESULT: if (rd_data) begin
				if (op_q == `DSSC_OP_SENSE_INT && ridx_q == 2'h0 && res_q[0] != `DSSC_CAUSE_INVALID)
					int_d = 1'b0;
				ridx_d = ridx_q + 2'h1;
				if (ridx_q + 2'h1 == rcnt_q)
					st_d = dssc_pkg::CMD_OPCODE;
			end
		endcase
		for (int i = 3; i >= 0; i--) begin
			if (drive_ready[i])
				pick = 2'(i);
		end
		// Only positioning and polling latch the interrupt; routine ones never wait here
		if (poll_q && st_q == dssc_pkg::CMD_OPCODE && !int_q && |drive_ready) begin
			poll_d = 1'b0;
			int_d = 1'b1;
			cause_d = {`DSSC_CAUSE_POLL, 1'b0, 3'h0, pick};
		end
		// Set beats a same-cycle clear by the host's read
		if (sk_fin) begin
			int_d = 1'b1;
			busy_d = 4'h0;
			cause_d = sk_cause;
			if (!abn_q)
				trk_d[skdrv_q] = sktgt_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= dssc_pkg::CMD_OPCODE;
			op_q <= 8'h00;
			need_q <= 2'h0;
			bcnt_q <= 2'h0;
			rcnt_q <= 2'h0;
			ridx_q <= 2'h0;
			int_q <= 1'b0;
			cause_q <= 8'h00;
			busy_q <= 4'h0;
			poll_q <= 1'b1;
			sel_q <= 2'h0;
			head_q <= 1'b0;
			for (int i = 0; i < 4; i++) begin
				par_q[i] <= 8'h00;
				res_q[i] <= 8'h00;
				trk_q[i] <= 12'h000;
			end
		end else begin
			st_q <= st_d;
			op_q <= op_d;
			need_q <= need_d;
			bcnt_q <= bcnt_d;
			rcnt_q <= rcnt_d;
			ridx_q <= ridx_d;
			int_q <= int_d;
			cause_q <= cause_d;
			busy_q <= busy_d;
			poll_q <= poll_d;
			sel_q <= sel_d;
			head_q <= head_d;
			par_q <= par_d;
			res_q <= res_d;
			trk_q <= trk_d;
		end
	end

	// ----------------------------------------
	// Seek engine
	// ----------------------------------------
	always_comb begin
		sk_d = sk_q;
		skdrv_d = skdrv_q;
		sktgt_d = sktgt_q;
		steps_d = steps_q;
		dir_d = dir_q;
		abn_d = abn_q;
		step_n_d = step_n_q;
		wcnt_d = wcnt_q;
		sk_fin = 1'b0;
		do_pulse = 1'b0;
		tstart = 1'b0;
		tmult = 8'(`DSSC_STEP_SPAN - {1'b0, cfg_q[`DSSC_CFG_STEP_RATE]});
		tunit = dssc_step_unit(cfg_q[`DSSC_CFG_RATE]);
		sk_cause = {abn_q ? `DSSC_CAUSE_ABNORMAL : `DSSC_CAUSE_NORMAL, 1'b1, 2'h0, head_q,
			skdrv_q};
		if (!step_n_q) begin
			wcnt_d = wcnt_q + 8'h1;
			if (wcnt_q == STEP_W_CYC - 8'h1)
				step_n_d = 1'b1;
		end
		unique case (sk_q)
			dssc_pkg::SK_IDLE: if (seek_go) begin
				sk_d = dssc_pkg::SK_DELAY;
				skdrv_d = ds;
				sktgt_d = tgt;
				dir_d = tgt > cur;
				steps_d = (tgt > cur) ? tgt - cur : cur - tgt;
				abn_d = !drive_ready[dssc_phys(ds, cfg_q)];
				tstart = 1'b1;
				tmult = cfg_q[`DSSC_CFG_DBP];
				tunit = dssc_dbp_unit(cfg_q[`DSSC_CFG_RATE]);
			end
			dssc_pkg::SK_DELAY: if (tdone) begin
				if (abn_q || steps_q == 12'h000) begin
					sk_fin = 1'b1;
					sk_d = dssc_pkg::SK_IDLE;
				end else begin
					do_pulse = 1'b1;
				end
			end
			dssc_pkg::SK_STEP: if (tdone) begin
				// The last period elapses before the interrupt
				if (steps_q == 12'h000) begin
					sk_fin = 1'b1;
					sk_d = dssc_pkg::SK_IDLE;
				end else begin
					do_pulse = 1'b1;
				end
			end
		endcase
		if (do_pulse) begin
			sk_d = dssc_pkg::SK_STEP;
			step_n_d = 1'b0;
			wcnt_d = 8'h00;
			steps_d = steps_q - 12'h001;
			tstart = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sk_q <= dssc_pkg::SK_IDLE;
			skdrv_q <= 2'h0;
			sktgt_q <= 12'h000;
			steps_q <= 12'h000;
			dir_q <= 1'b0;
			abn_q <= 1'b0;
			step_n_q <= 1'b1;
			wcnt_q <= 8'h00;
		end else begin
			sk_q <= sk_d;
			skdrv_q <= skdrv_d;
			sktgt_q <= sktgt_d;
			steps_q <= steps_d;
			dir_q <= dir_d;
			abn_q <= abn_d;
			step_n_q <= step_n_d;
			wcnt_q <= wcnt_d;
		end
	end

	dssc_interval_timer u_timer (
		.pclk(pclk),
		.presetn(presetn),
		.start(tstart),
		.mult(tmult),
		.unit_us(tunit),
		.cyc_per_us(CYC_PER_US),
		.done(tdone)
	);

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign step_n = step_n_q;
	assign dir_out = dir_q;
	assign drive_sel = sel_q;
	assign head_sel = head_q;
	assign int_req = int_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking dssc_cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_seek_busy_set: assert property (seek_go |=> busy_q[$past(ds)]) else $error("busy not set");
	a_delay_no_step: assert property (sk_q == dssc_pkg::SK_DELAY |-> step_n_q) else $error("early step");
	a_dir_target: assert property (sk_q == dssc_pkg::SK_STEP |-> dir_q == (sktgt_q > trk_q[skdrv_q]))
		else $error("direction wrong");
	a_seek_no_result: assert property (seek_go |=> st_q == dssc_pkg::CMD_OPCODE ##1 !int_q)
		else $error("seek result or early int");
	a_invalid_sense: assert property (st_q == dssc_pkg::CMD_EXEC && op_q == `DSSC_OP_SENSE_INT && !int_q
		|=> res_q[0] == `DSSC_CAUSE_INVALID && rcnt_q == `DSSC_ONE_RES) else $error("sense not invalid");
	a_sense_count: assert property (st_q == dssc_pkg::CMD_EXEC && op_q == `DSSC_OP_SENSE_INT && int_q
		|=> rcnt_q == (cfg_q[`DSSC_CFG_XTR] ? `DSSC_SINT_RES_XTR : `DSSC_SINT_RES)) else $error("count");
	a_int_clear_read: assert property (rd_data && op_q == `DSSC_OP_SENSE_INT && ridx_q == 2'h0
		&& st_q == dssc_pkg::CMD_RESULT && int_q && !sk_fin |=> !int_q) else $error("int kept");
	a_poll_once: assert property (!poll_q |=> !poll_q) else $error("poll rearmed");
	a_fin_clears_busy: assert property (sk_fin && !seek_go |=> int_q && busy_q == 4'h0)
		else $error("busy after seek");
	a_trk_target: assert property (sk_fin && !abn_q |=> trk_q[$past(skdrv_q)] == $past(sktgt_q))
		else $error("track not updated");
	a_rqm_bit: assert property (psel && penable && !pready_q && !pwrite && paddr == `DSSC_ADDR_STAT
		|=> prdata_q[7] == $past(host_request_flag)) else $error("request flag");
	c_seek_done: cover property (sk_fin && !abn_q && $past(sk_q) == dssc_pkg::SK_STEP);
	c_sense_int: cover property (rd_data && op_q == `DSSC_OP_SENSE_INT && ridx_q == 2'h1);
	c_set_write: cover property (st_q == dssc_pkg::CMD_EXEC && op_q[`DSSC_OP_WNR]);
	c_poll_int: cover property (poll_q ##1 !poll_q);
endmodule // dssc_top
`default_nettype wire

/* File: hdl/dssc_defs.svh */
// Purpose: Constants of the seek and sense command block
// Assumes: pclk at 100 MHz
// Notes: Definitions only
`ifndef DSSC_DEFS_SVH
`define DSSC_DEFS_SVH
// ----------------------------------------
// Register map and fields
// ----------------------------------------
`define DSSC_ADDR_DATA 8'h00
`define DSSC_ADDR_STAT 8'h04
`define DSSC_ADDR_CFG 8'h08
`define DSSC_CFG_XTR 0
`define DSSC_CFG_FOUR 1
`define DSSC_CFG_EXCH 2
`define DSSC_CFG_RATE 5:4
`define DSSC_CFG_STEP_RATE 11:8
`define DSSC_CFG_DBP 23:16
`define DSSC_CFG_MASK 32'h00ff0f37
`define DSSC_CFG_RST 32'h00000000
// ----------------------------------------
// Commands and result codes
// ----------------------------------------
`define DSSC_OP_SEEK 8'h0f
`define DSSC_OP_SENSE_DRV 8'h04
`define DSSC_OP_SENSE_INT 8'h08
`define DSSC_OP_SET_TRK 8'h21
`define DSSC_OP_SET_TRK_MASK 8'hbf
`define DSSC_OP_WNR 6
`define DSSC_STRK_TAG 5'h06
`define DSSC_SEEK_BYTES 2'h2
`define DSSC_SEEK_BYTES_XTR 2'h3
`define DSSC_SDS_BYTES 2'h1
`define DSSC_STRK_BYTES 2'h2
`define DSSC_SINT_RES 2'h2
`define DSSC_SINT_RES_XTR 2'h3
`define DSSC_ONE_RES 2'h1
`define DSSC_CAUSE_INVALID 8'h80
`define DSSC_CAUSE_NORMAL 2'h0
`define DSSC_CAUSE_ABNORMAL 2'h1
`define DSSC_CAUSE_POLL 2'h3
`define DSSC_DSTAT_TWO_SIDE 1'b1
// ----------------------------------------
// Timing
// ----------------------------------------
`define DSSC_CLK_MHZ 100
`define DSSC_RATE_500K 2'h0
`define DSSC_RATE_300K 2'h1
`define DSSC_RATE_250K 2'h2
`define DSSC_RATE_1M 2'h3
`define DSSC_STEP_SPAN 5'h10
`define DSSC_STEP_US_1M 12'h1f4
`define DSSC_STEP_US_500K 12'h3e8
`define DSSC_STEP_US_300K 12'h686
`define DSSC_STEP_US_250K 12'h7d0
`define DSSC_DBP_US_FAST 12'h3e8
`define DSSC_DBP_US_300K 12'hd05
`define DSSC_DBP_US_250K 12'hfa0
`define DSSC_STEP_WIDTH_US 1
`endif

/* File: hdl/dssc_pkg.sv */
// Purpose: Types of the seek and sense command block
// Assumes: Nothing
// Notes: Constants live in dssc_defs.svh
package dssc_pkg;
	typedef enum logic [1:0] {CMD_OPCODE, CMD_PARAM, CMD_EXEC, CMD_RESULT} dssc_cmd_t;
	typedef enum logic [1:0] {SK_IDLE, SK_DELAY, SK_STEP} dssc_seek_t;
	typedef logic [11:0] dssc_track_t;
endpackage

/* File: hdl/dssc_interval_timer.sv */
// Purpose: Millisecond-scale interval timer for seek delays and step periods
// Assumes: start is a one-cycle pulse
// Notes: done pulses mult*unit_us*cyc_per_us cycles after start, or 2 cycles after start when that product is below 2
`timescale 1ns/1ps
`default_nettype none
module dssc_interval_timer (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start,
	input wire logic [7:0] mult,
	input wire logic [11:0] unit_us,
	input wire logic [7:0] cyc_per_us,
	output logic done
);
	logic [31:0] cnt_q, cnt_d;
	logic run_q, run_d, done_q, done_d;

	always_comb begin
		cnt_d = cnt_q;
		run_d = run_q;
		done_d = 1'b0;
		if (start) begin
			cnt_d = 32'(mult) * 32'(unit_us) * 32'(cyc_per_us);
			run_d = 1'b1;
		end else if (run_q) begin
			// Done is registered, so stop one count early to hit the period exactly
			if (cnt_q <= 32'h2) begin
				run_d = 1'b0;
				done_d = 1'b1;
			end else begin
				cnt_d = cnt_q - 32'h1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 32'h0;
			run_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			run_q <= run_d;
			done_q <= done_d;
		end
	end

	assign done = done_q;
endmodule // dssc_interval_timer
`default_nettype wire

/* File: testbench/dssc_drive_model.sv */
// Purpose: Drive mechanism model behind step and direction
// Assumes: step_n active low, dir_out high moves toward higher tracks
// Notes: Head of every drive starts at track 0
`timescale 1ns/1ps
`default_nettype none
module dssc_drive_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic step_n,
	input wire logic dir_out,
	input wire logic [1:0] drive_sel,
	output logic [3:0] track_zero,
	output logic [15:0] steps,
	output logic [31:0] period,
	output logic [31:0] since,
	output logic last_dir
);
	logic [11:0] pos_q [4];
	logic prev_q;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_q <= 1'h1;
			steps <= 16'h0;
			period <= 32'h0;
			since <= 32'h0;
			last_dir <= 1'h0;
			for (int i = 0; i < 4; i++) pos_q[i] <= 12'h000;
		end else begin
			prev_q <= step_n;
			since <= since + 32'h1;
			// Falling edge only, so a long pulse moves the head once
			if (prev_q && !step_n) begin
				steps <= steps + 16'h1;
				period <= since + 32'h1;
				since <= 32'h0;
				last_dir <= dir_out;
				pos_q[drive_sel] <= dir_out ? pos_q[drive_sel] + 12'h1 : pos_q[drive_sel] - 12'h1;
			end
		end
	end
	always_comb for (int i = 0; i < 4; i++) track_zero[i] = (pos_q[i] == 12'h000);
endmodule // dssc_drive_model
`default_nettype wire

/* File: testbench/dssc_top_tb.sv */
// Purpose: Self-checking bench of the seek and sense command block
// Assumes: CYC_PER_US of 1, so each microsecond of timing shrinks to one cycle
// Notes: Fixed seed; step spacing is measured by the drive model
`timescale 1ns/1ps
`default_nettype none
`include "dssc_defs.svh"
module dssc_top_tb;
	logic pclk;
	logic presetn;
	logic psel;
	logic penable;
	logic pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [3:0] drive_ready;
	logic [3:0] track_zero;
	logic [3:0] write_protect;
	logic step_n;
	logic dir_out;
	logic [1:0] drive_sel;
	logic head_sel;
	logic int_req;
	logic [15:0] steps;
	logic [31:0] period;
	logic [31:0] since;
	logic last_dir;
	int n_fail = 0;
	int num_checks = 0;
	int cyc = 0;
	logic [31:0] rdv;
	logic err;
	logic xtr;
	logic [3:0] step_rate;
	logic [1:0] rate;
	logic [1:0] d;
	dssc_pkg::dssc_track_t t;
	dssc_pkg::dssc_track_t cur [2];
	dssc_top #(.CYC_PER_US(8'h01)) i_dssc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .drive_ready(drive_ready), .track_zero(track_zero),
		.write_protect(write_protect), .step_n(step_n), .dir_out(dir_out),
		.drive_sel(drive_sel), .head_sel(head_sel), .int_req(int_req));
	dssc_drive_model i_dssc_drive_model (.pclk(pclk), .presetn(presetn), .step_n(step_n),
		.dir_out(dir_out), .drive_sel(drive_sel), .track_zero(track_zero), .steps(steps),
		.period(period), .since(since), .last_dir(last_dir));
	always #5 pclk = ~pclk;
	// ----------------------------------------
	// Bus cycles and comparisons
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= dat;
		@(posedge pclk);
		penable <= 1'h1;
		// Only the bench ceiling ends a wait that never sees pready
		do begin
			@(posedge pclk);
		end while (pready !== 1'h1);
		rdv = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask
	task automatic wb(input logic [7:0] b);
		apb(1'h1, `DSSC_ADDR_DATA, {24'h0, b});
	endtask
	task automatic rd_chk(input string nm, input logic [7:0] e, input logic [7:0] m);
		apb(1'h0, `DSSC_ADDR_DATA, 32'h0);
		chk(nm, 32'(e & m), rdv & 32'(m));
	endtask
	task automatic setcfg();
		apb(1'h1, `DSSC_ADDR_CFG, {20'h0, step_rate, 2'h0, rate, 3'h0, xtr});
	endtask
	function automatic logic [31:0] step_cyc();
		logic [31:0] u;
		case (rate)
			`DSSC_RATE_1M: u = 32'h1f4;
			`DSSC_RATE_300K: u = 32'h686;
			`DSSC_RATE_250K: u = 32'h7d0;
			default: u = 32'h3e8;
		endcase
		return (32'h10 - 32'(step_rate)) * u;
	endfunction
	// ----------------------------------------
	// Commands
	// ----------------------------------------
	task automatic sense(input logic [7:0] cause, input logic [7:0] m, input logic head,
		input logic [1:0] ds);
		wb(`DSSC_OP_SENSE_INT);
		rd_chk("cause", cause | {5'h0, head, ds}, m);
		chk("int_clr", 0, 32'(int_req));
		rd_chk("trk_lo", cur[ds][7:0], 8'hff);
		if (xtr) rd_chk("trk_hi", {cur[ds][11:8], 4'h0}, 8'hff);
	endtask
	task automatic sdrv(input logic [1:0] ds, input logic head);
		wb(`DSSC_OP_SENSE_DRV);
		wb({5'h0, head, ds});
		rd_chk("drv_stat", {1'h0, write_protect[ds], drive_ready[ds], track_zero[ds], 1'h1,
			head, ds}, 8'hff);
		chk("drv_stat_int", 0, 32'(int_req));
	endtask
	task automatic strk(input logic wnr, input logic msb, input logic [7:0] v, input logic [7:0] e);
		wb(wnr ? 8'h61 : 8'h21);
		wb({5'h06, msb, 2'h0});
		wb(v);
		rd_chk("strk", e, 8'hff);
		chk("strk_int", 0, 32'(int_req));
	endtask
	task automatic seek(input logic [1:0] ds, input logic head, input logic [11:0] tg,
		input logic ok);
		logic [15:0] s0;
		logic [31:0] per;
		int n;
		s0 = steps;
		per = step_cyc();
		n = 0;
		wb(`DSSC_OP_SEEK);
		wb({5'h0, head, ds});
		wb(tg[7:0]);
		if (xtr) wb({tg[11:8], 4'h0});
		apb(1'h0, `DSSC_ADDR_STAT, 32'h0);
		if (ok) chk("busy", 32'h1 << ds, rdv & 32'hf);
		// Nothing else goes to the block while this one drive moves
		while (int_req !== 1'h1 && n < 30000) begin
			@(posedge pclk);
			n++;
		end
		chk("int_seen", 1, 32'(int_req));
		chk("steps", ok ? 32'(tg > cur[ds] ? tg - cur[ds] : cur[ds] - tg) : 0,
			32'(steps - s0));
		if (ok) begin
			chk("dir", 32'(tg > cur[ds]), 32'(last_dir));
			chk("period", per, period);
			chk("int_gap", 1, 32'(since + 4 >= per && since <= per + 4));
			chk("drv", 32'(ds), 32'(drive_sel));
			chk("head", 32'(head), 32'(head_sel));
			cur[ds] = tg;
		end
		apb(1'h0, `DSSC_ADDR_STAT, 32'h0);
		chk("idle", 32'h80, rdv & 32'hdf);
		sense(ok ? 8'h20 : 8'h40, ok ? 8'hff : 8'hc7, head, ds);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Ceiling well above the longest seek sequence
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 90000) begin
			n_fail++;
			$display("ERROR timeout expected finish seen hang");
			conclude();
		end
	end
	initial begin
		pclk = 1'h0;
		presetn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		drive_ready = 4'h3;
		xtr = 1'h0;
		cur[0] = 12'h000;
		cur[1] = 12'h000;
		void'($urandom(93479));
		write_protect = 4'($urandom());
		repeat (3) @(posedge pclk);
		presetn <= 1'h1;
		repeat (4) @(posedge pclk);
		chk("poll_int", 1, 32'(int_req));
		sense(8'hc0, 8'hff, 1'h0, 2'h0);
		wb(`DSSC_OP_SENSE_INT);
		rd_chk("inval", `DSSC_CAUSE_INVALID, 8'hff);
		apb(1'h0, 8'h0c, 32'h0);
		chk("slverr", 1, 32'(err));
		$display("test reset done");
		step_rate = 4'he + 4'($urandom_range(1));
		for (int r = 0; r < 4; r++) begin
			rate = 2'(r);
			setcfg();
			d = 2'($urandom_range(1));
			t = cur[d] < 12'h005 ? cur[d] + 12'h002 + 12'($urandom_range(1))
				: cur[d] - 12'h002 - 12'($urandom_range(1));
			seek(d, 1'($urandom()), t, 1'h1);
			sdrv(d, 1'($urandom()));
		end
		$display("test seek done");
		xtr = 1'h1;
		rate = `DSSC_RATE_500K;
		setcfg();
		strk(1'h1, 1'h1, 8'h01, 8'h01);
		strk(1'h1, 1'h0, 8'h02, 8'h02);
		strk(1'h0, 1'h0, 8'h00, 8'h02);
		cur[0] = 12'h102;
		seek(2'h0, 1'h0, 12'h105, 1'h1);
		$display("test extended done");
		drive_ready <= 4'h1;
		@(posedge pclk);
		seek(2'h1, 1'h0, cur[1] + 12'h003, 1'h0);
		$display("test abnormal done");
		conclude();
	end
endmodule // dssc_top_tb
`default_nettype wire
